// ==== src/asr_host.sv ====
/*
 * asr_host: host controller for an asynchronous 16-bit static memory
 * with upper and lower byte lanes; one request at a time.
 * Assumes req_* from logic on clk; mem_dq_i comes from the pins.
 */
// Overview of operation
// - write data held past write end
// - host drives bus only after release
// - strobe at least setup plus release time
// - write strobe high throughout reads
// - address set in the same cycle as selects and lanes
// - selects always at definite levels
module asr_host
	import asr_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 req_valid,
	input  wire logic                 req_write,
	input  wire logic [ADDR_W-1:0]    req_addr,
	input  wire logic [LANE_W-1:0]    req_lanes,
	input  wire logic [DATA_W-1:0]    req_wdata,
	output logic                      req_ready,
	output logic                      rsp_valid,
	output logic [DATA_W-1:0]         rsp_rdata,
	output logic [ADDR_W-1:0]         mem_addr,
	output logic                      select_low_active_n,
	output logic                      select_high_active,
	output logic                      write_strobe_n,
	output logic                      output_drive_n,
	output logic                      upper_lane_enable_n,
	output logic                      lower_lane_enable_n,
	output logic [DATA_W-1:0]         mem_dq_o,
	output logic [DATA_W-1:0]         mem_dq_oe,
	input  wire logic [DATA_W-1:0]    mem_dq_i
);
	import asr_pkg::*;

	typedef struct packed {
		asr_state_e        st;
		logic [CNT_W-1:0]  cnt;
		logic [ADDR_W-1:0] addr;
		logic [LANE_W-1:0] lanes;
		logic [DATA_W-1:0] wdata;
		logic              sel;
		logic              write;
		logic              read;
		logic              drive;
		logic              ready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
	} asr_host_s;

	asr_host_s s_q;
	asr_host_s s_d;
	asr_pin_if pin ();

	// pin stage adds one cycle, the synchroniser two
	localparam int unsigned SAMPLE_LAG = 3;
	localparam logic [CNT_W-1:0] READ_END  = CNT_W'(READ_CYC + SAMPLE_LAG);
	localparam logic [CNT_W-1:0] WRITE_END = CNT_W'(WRITE_CYC);
	localparam logic [CNT_W-1:0] REC_END   = CNT_W'(RECOVER_CYC);

	function automatic logic [DATA_W-1:0] lane_mask(
			input logic [LANE_W-1:0] l);
		return {{8{l[1]}}, {8{l[0]}}};
	endfunction : lane_mask

	always_comb begin
		s_d = s_q;
		s_d.sync1 = mem_dq_i;
		s_d.sync2 = s_q.sync1;
		s_d.rvalid = 1'b0;
		s_d.cnt = s_q.cnt + CNT_W'(1);
		unique case (s_q.st)
			ASR_IDLE: begin
				s_d.cnt = '0;
				s_d.ready = 1'b1;
				// a request with no lane would leave the memory deselected
				if (req_valid && s_q.ready &&
						req_lanes != LANE_NONE) begin
					s_d.ready = 1'b0;
					s_d.addr = req_addr;
					s_d.lanes = req_lanes;
					s_d.wdata = req_wdata;
					s_d.sel = 1'b1;
					s_d.write = 1'b0;
					s_d.read = ~req_write;
					s_d.drive = req_write;
					s_d.st = req_write ? ASR_WRITE : ASR_READ;
				end
			end
			ASR_READ: begin
				if (s_q.cnt == READ_END) begin
					s_d.rdata = s_q.sync2 & lane_mask(s_q.lanes);
					s_d.rvalid = 1'b1;
					s_d.sel = 1'b0;
					s_d.read = 1'b0;
					s_d.cnt = '0;
					s_d.st = ASR_RECOVER;
				end
			end
			ASR_WRITE: begin
				// data set up one cycle before the strobe overlap opens
				s_d.write = 1'b1;
				if (s_q.cnt == WRITE_END) begin
					s_d.write = 1'b0;
					s_d.cnt = '0;
					s_d.st = ASR_RECOVER;
				end
			end
			ASR_RECOVER: begin
				// selects drop with strobe high so outputs stay floating
				s_d.sel = 1'b0;
				s_d.drive = 1'b0;
				s_d.lanes = LANE_NONE;
				if (s_q.cnt == REC_END) begin
					s_d.st = ASR_IDLE;
					s_d.ready = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{st: ASR_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign pin.addr  = s_q.addr;
	assign pin.sel   = s_q.sel;
	assign pin.write = s_q.write;
	assign pin.read  = s_q.read;
	assign pin.lanes = s_q.lanes;
	assign pin.drive = s_q.drive;
	assign pin.wdata = s_q.wdata;

	assign req_ready = s_q.ready;
	assign rsp_valid = s_q.rvalid;
	assign rsp_rdata = s_q.rdata;

	asr_pin_stage u_pins (
		.clk                 (clk),
		.rstn                (rstn),
		.pin                 (pin),
		.mem_addr            (mem_addr),
		.select_low_active_n (select_low_active_n),
		.select_high_active  (select_high_active),
		.write_strobe_n      (write_strobe_n),
		.output_drive_n      (output_drive_n),
		.upper_lane_enable_n (upper_lane_enable_n),
		.lower_lane_enable_n (lower_lane_enable_n),
		.mem_dq_o            (mem_dq_o),
		.mem_dq_oe           (mem_dq_oe)
	);

endmodule : asr_host

// ==== src/asr_pkg.sv ====
/*
 * asr_pkg: constants and types for the host controller of an asynchronous
 * 16-bit static memory with two byte lanes.
 * Assumes a 40 MHz system clock; all pin timings are converted here.
 */
package asr_pkg;

	localparam int unsigned CLK_PERIOD_PS = 25000;

	localparam int unsigned ADDR_W = 21;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned LANE_W = 2;

	// least times in ns, as printed
	localparam int unsigned READ_CYCLE_NS       = 70;
	localparam int unsigned WRITE_PULSE_NS      = 45;
	localparam int unsigned WRITE_END_NS        = 60;
	localparam int unsigned WRITE_DATA_SETUP_NS = 30;
	localparam int unsigned STROBE_TO_HIZ_NS    = 25;
	localparam int unsigned WRITE_CYCLE_NS      = 70;
	localparam int unsigned BUS_RELEASE_NS      = 25;

	function automatic int unsigned asr_cycles_up(input int unsigned ns);
		int unsigned c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : asr_cycles_up

	function automatic int unsigned asr_max(input int unsigned a,
			input int unsigned b);
		return (a > b) ? a : b;
	endfunction : asr_max

	localparam int unsigned READ_CYC = asr_cycles_up(READ_CYCLE_NS);
	localparam int unsigned WRITE_CYC = asr_max(asr_max(
		asr_cycles_up(WRITE_PULSE_NS), asr_cycles_up(WRITE_END_NS)),
		asr_cycles_up(WRITE_DATA_SETUP_NS + STROBE_TO_HIZ_NS));
	localparam int unsigned DATA_SETUP_CYC = asr_cycles_up(WRITE_DATA_SETUP_NS);
	localparam int unsigned RECOVER_CYC = asr_cycles_up(
		asr_max(BUS_RELEASE_NS, WRITE_CYCLE_NS - WRITE_END_NS));

	localparam int unsigned CNT_W = 4;

	localparam logic [1:0] LANE_NONE = 2'h0;

	typedef enum logic [1:0] {
		ASR_IDLE,
		ASR_READ,
		ASR_WRITE,
		ASR_RECOVER
	} asr_state_e;

endpackage : asr_pkg

// ==== src/asr_pin_if.sv ====
/*
 * asr_pin_if: pin-side signals between the sequencer and its pin stage.
 * Assumes both ends share clk.
 */
interface asr_pin_if;
	logic [asr_pkg::ADDR_W-1:0] addr;
	logic                       sel;
	logic                       write;
	logic                       read;
	logic [asr_pkg::LANE_W-1:0] lanes;
	logic                       drive;
	logic [asr_pkg::DATA_W-1:0] wdata;

	modport seq (output addr, sel, write, read, lanes, drive, wdata);
	modport pins (input addr, sel, write, read, lanes, drive, wdata);
endinterface : asr_pin_if

// ==== src/asr_pin_stage.sv ====
/*
 * asr_pin_stage: registers every memory pin from the sequencer's intent.
 * Assumes the sequencer never asks for drive while read is active.
 */
module asr_pin_stage
	import asr_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	asr_pin_if.pins                   pin,
	output logic [ADDR_W-1:0]         mem_addr,
	output logic                      select_low_active_n,
	output logic                      select_high_active,
	output logic                      write_strobe_n,
	output logic                      output_drive_n,
	output logic                      upper_lane_enable_n,
	output logic                      lower_lane_enable_n,
	output logic [DATA_W-1:0]         mem_dq_o,
	output logic [DATA_W-1:0]         mem_dq_oe
);
	import asr_pkg::*;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              cs1_n;
		logic              cs2;
		logic              we_n;
		logic              oe_n;
		logic              ub_n;
		logic              lb_n;
		logic [DATA_W-1:0] dq;
		logic [DATA_W-1:0] oe;
	} asr_pins_s;

	asr_pins_s s_q;
	asr_pins_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.addr = pin.addr;
		// selects always driven to a definite level
		s_d.cs1_n = ~pin.sel;
		s_d.cs2 = pin.sel;
		s_d.we_n = ~pin.write;
		s_d.oe_n = ~pin.read;
		s_d.ub_n = ~pin.lanes[1];
		s_d.lb_n = ~pin.lanes[0];
		s_d.dq = pin.wdata;
		s_d.oe = {DATA_W{pin.drive}};
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{addr: '0, cs1_n: 1'b1, cs2: 1'b0, we_n: 1'b1,
				oe_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1, dq: '0, oe: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign mem_addr            = s_q.addr;
	assign select_low_active_n = s_q.cs1_n;
	assign select_high_active  = s_q.cs2;
	assign write_strobe_n      = s_q.we_n;
	assign output_drive_n      = s_q.oe_n;
	assign upper_lane_enable_n = s_q.ub_n;
	assign lower_lane_enable_n = s_q.lb_n;
	assign mem_dq_o            = s_q.dq;
	assign mem_dq_oe           = s_q.oe;

endmodule : asr_pin_stage

// ==== verification/asr_host_props.sv ====
/*
 * asr_host_props: pin-level checks on the memory host controller.
 * Assumes a bind onto asr_host; sees only its ports.
 */
module asr_host_props
	import asr_pkg::*;
(
	input wire logic		clk,
	input wire logic		rstn,
	input wire logic		rsp_valid,
	input wire logic [ADDR_W-1:0]	mem_addr,
	input wire logic		select_low_active_n,
	input wire logic		select_high_active,
	input wire logic		write_strobe_n,
	input wire logic		output_drive_n,
	input wire logic		upper_lane_enable_n,
	input wire logic		lower_lane_enable_n,
	input wire logic [DATA_W-1:0]	mem_dq_o,
	input wire logic [DATA_W-1:0]	mem_dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_sel_levels: assert property (
		select_high_active == !select_low_active_n) else $error("selects");
	a_read_strobe: assert property (
		!output_drive_n |-> write_strobe_n) else $error("strobe in read");
	a_bus_fight: assert property (
		mem_dq_oe != '0 |-> output_drive_n) else $error("bus fight");
	a_strobe_len: assert property (
		$fell(write_strobe_n) |-> !write_strobe_n [*3]) else $error("short");
	a_data_hold: assert property (
		$rose(write_strobe_n) |-> mem_dq_oe == '1 && $stable(mem_dq_o)
		&& !select_low_active_n) else $error("data hold");
	a_data_first: assert property (
		$fell(write_strobe_n) |-> $past(mem_dq_oe) == '1) else $error("setup");
	a_write_lane: assert property (
		!write_strobe_n |-> !(upper_lane_enable_n && lower_lane_enable_n))
		else $error("no lane");
	a_read_addr: assert property (
		!output_drive_n && $past(!output_drive_n) |-> $stable(mem_addr))
		else $error("addr moved");
	a_read_answer: assert property (
		$fell(output_drive_n) |-> ##6 rsp_valid) else $error("no answer");
	a_idle_float: assert property (
		select_low_active_n |-> mem_dq_oe == '0 && write_strobe_n)
		else $error("idle drive");
endmodule : asr_host_props

bind asr_host asr_host_props asr_host_props_i (.clk, .rstn, .rsp_valid,
	.mem_addr, .select_low_active_n, .select_high_active, .write_strobe_n,
	.output_drive_n, .upper_lane_enable_n, .lower_lane_enable_n,
	.mem_dq_o, .mem_dq_oe);

// ==== verification/asr_mem_model.sv ====
/*
 * asr_mem_model: behavioural 16-bit memory with two byte lanes.
 * Assumes word addresses below 256; resolves the shared data bus.
 */
module asr_mem_model
	import asr_pkg::*;
(
	input wire logic [ADDR_W-1:0]	mem_addr,
	input wire logic		select_low_active_n,
	input wire logic		select_high_active,
	input wire logic		write_strobe_n,
	input wire logic		output_drive_n,
	input wire logic		upper_lane_enable_n,
	input wire logic		lower_lane_enable_n,
	input wire logic [DATA_W-1:0]	mem_dq_o,
	input wire logic [DATA_W-1:0]	mem_dq_oe,
	output logic [DATA_W-1:0]	bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] word;
	logic on, wr, rd;
	assign word = mem[mem_addr[7:0]];
	assign on = !select_low_active_n && select_high_active
		&& !(upper_lane_enable_n && lower_lane_enable_n);
	assign wr = on && !write_strobe_n;
	assign rd = on && write_strobe_n && !output_drive_n;
	// a floating lane shows the inverse of the stored byte
	assign bus[7:0] = mem_dq_oe[0] ? mem_dq_o[7:0]
		: (rd && !lower_lane_enable_n) ? word[7:0] : ~word[7:0];
	assign bus[15:8] = mem_dq_oe[8] ? mem_dq_o[15:8]
		: (rd && !upper_lane_enable_n) ? word[15:8] : ~word[15:8];
	always @(negedge wr) begin
		if (!lower_lane_enable_n) mem[mem_addr[7:0]][7:0] = bus[7:0];
		if (!upper_lane_enable_n) mem[mem_addr[7:0]][15:8] = bus[15:8];
	end
endmodule : asr_mem_model

// ==== verification/asr_host_test.sv ====
/*
 * asr_host_test: self-checking bench for asr_host with a memory model.
 * Assumes asr_host_props is bound in by its own file.
 */
module asr_host_test;
	import asr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, req_valid, req_write, req_ready, rsp_valid;
	logic [ADDR_W-1:0] req_addr, mem_addr;
	logic [LANE_W-1:0] req_lanes;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_dq_o, mem_dq_oe, bus, q;
	logic sl_n, sh, ws_n, od_n, ul_n, ll_n;
	int fails = 0;
	int samples_checked = 0;

	asr_host asr_host_i (.clk, .rstn, .req_valid, .req_write, .req_addr,
		.req_lanes, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
		.select_low_active_n(sl_n), .select_high_active(sh),
		.write_strobe_n(ws_n), .output_drive_n(od_n),
		.upper_lane_enable_n(ul_n), .lower_lane_enable_n(ll_n),
		.mem_dq_o, .mem_dq_oe, .mem_dq_i(bus));
	asr_mem_model asr_mem_model_i (.mem_addr, .select_low_active_n(sl_n),
		.select_high_active(sh), .write_strobe_n(ws_n),
		.output_drive_n(od_n), .upper_lane_enable_n(ul_n),
		.lower_lane_enable_n(ll_n), .mem_dq_o, .mem_dq_oe, .bus);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic complete_run();
		if (fails == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// rsp selects rsp_valid, otherwise req_ready
	task automatic wait_hi(input bit rsp);
		int n;
		n = 0;
		@(negedge clk);
		while ((rsp ? rsp_valid : req_ready) !== 1'b1) begin
			n++;
			if (n > 40) begin
				fails++;
				$display("MISMATCH %0t timeout", $time);
				complete_run();
			end
			@(negedge clk);
		end
	endtask : wait_hi

	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [1:0] l, input logic [15:0] d);
		wait_hi(1'b0);
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= {13'h0000, a};
		req_lanes <= l;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		if (!w) begin
			wait_hi(1'b1);
			q = rsp_rdata;
		end
	endtask : xfer

	task automatic t_word();
		xfer(1'b1, 8'h12, 2'h3, 16'hA5C3);
		xfer(1'b1, 8'h34, 2'h3, 16'h5A3C);
		xfer(1'b0, 8'h12, 2'h3, 16'h0000);
		chk(q, 16'hA5C3);
		xfer(1'b0, 8'h34, 2'h3, 16'h0000);
		chk(q, 16'h5A3C);
	endtask : t_word

	task automatic t_lanes();
		xfer(1'b1, 8'h12, 2'h1, 16'h1111);
		xfer(1'b0, 8'h12, 2'h3, 16'h0000);
		chk(q, 16'hA511);
		xfer(1'b1, 8'h12, 2'h2, 16'h2200);
		xfer(1'b0, 8'h12, 2'h3, 16'h0000);
		chk(q, 16'h2211);
		xfer(1'b0, 8'h12, 2'h1, 16'h0000);
		chk(q, 16'h0011);
		xfer(1'b0, 8'h12, 2'h2, 16'h0000);
		chk(q, 16'h2200);
	endtask : t_lanes

	task automatic t_none();
		wait_hi(1'b0);
		@(posedge clk);
		req_valid <= 1'b1;
		req_lanes <= 2'h0;
		repeat (3) @(negedge clk);
		chk({12'h000, req_ready, sl_n, ws_n, od_n}, 16'h000F);
		chk(mem_dq_oe, 16'h0000);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : t_none

	initial begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_lanes = '0;
		req_wdata = '0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		t_word();
		t_lanes();
		t_none();
		complete_run();
	end
endmodule : asr_host_test
